// *** bfw_pkg.sv ***
// constants of the byte fifo with watermark flags
//------------------------------------------------------------
//------------------------------------------------------------
package bfw_pkg;

  // register offsets
  localparam logic [7:0] OFS_CONTROL = 8'h02;
  localparam logic [7:0] OFS_THRESHOLD = 8'h03;
  localparam logic [7:0] OFS_FILL_COUNT = 8'h04;
  localparam logic [7:0] OFS_DATA_PORT = 8'h05;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h06;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h07;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h08;

  // control register fields
  localparam int CTL_CAPACITY_SELECT = 7;
  localparam int CTL_NEAR_FULL = 6;
  localparam int CTL_NEAR_EMPTY = 5;
  localparam int CTL_BUFFER_CLEAR = 4;
  localparam int CTL_THRESHOLD_MSB = 2;

  // interrupt register fields
  localparam int IRQ_NEAR_EMPTY_EVENT = 0;
  localparam int IRQ_NEAR_FULL_EVENT = 1;

  // capacities in bytes
  localparam logic [9:0] CAPACITY_SMALL = 10'h0ff;
  localparam logic [9:0] CAPACITY_LARGE = 10'h200;

  // reset values
  localparam logic RST_CAPACITY_SELECT = 1'b0;
  localparam logic RST_THRESHOLD_MSB = 1'b0;
  localparam logic [7:0] RST_THRESHOLD = 8'h00;
  localparam logic [9:0] RST_FILL_COUNT = 10'h000;
  localparam logic [1:0] RST_IRQ_ENABLE = 2'h0;
  localparam logic [7:0] RST_ADDR_POINTER = 8'h00;
  localparam logic [7:0] RST_READ_DATA = 8'h00;

endpackage

// *** bfw_mem_if.sv ***
// port between the fifo control and its storage array
`timescale 1ns/1ps
interface bfw_mem_if #(
  parameter int ADDR_WIDTH = 9,
  parameter int DATA_WIDTH = 8
);
  logic writeEnable;
  logic [ADDR_WIDTH-1:0] writeAddr;
  logic [DATA_WIDTH-1:0] writeData;
  logic [ADDR_WIDTH-1:0] readAddr;
  logic [DATA_WIDTH-1:0] readData;

  modport ctrl (
    output writeEnable,
    output writeAddr,
    output writeData,
    output readAddr,
    input readData
  );

  modport store (
    input writeEnable,
    input writeAddr,
    input writeData,
    input readAddr,
    output readData
  );
endinterface

// *** bfw_sticky_flag.sv ***
// sticky event flag, the set wins over a clear in the same cycle
`timescale 1ns/1ps
module bfw_sticky_flag (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic set,
  input wire logic clear,
  output logic flag
);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flag <= 1'b0;
    end else if (ce) begin
      flag <= set | (flag & ~clear);
    end
  end

endmodule

// *** bfw_mem.sv ***
// byte storage array with registered, write-through read port
`timescale 1ns/1ps
module bfw_mem #(
  parameter int DEPTH = 512,
  parameter int ADDR_WIDTH = 9,
  parameter int DATA_WIDTH = 8
) (
  input wire logic clk,
  input wire logic ce,
  bfw_mem_if.store port
);

  logic [DATA_WIDTH-1:0] store [DEPTH];

  // write-through keeps the read register equal to the head byte even
  // when the head slot is written in the same cycle
  always_ff @(posedge clk) begin
    if (ce) begin
      if (port.writeEnable) begin
        store[port.writeAddr] <= port.writeData;
      end
      if (port.writeEnable && port.writeAddr == port.readAddr) begin
        port.readData <= port.writeData;
      end else begin
        port.readData <= store[port.readAddr];
      end
    end
  end

endmodule

// *** bfw_byte_fifo.sv ***
// byte fifo with capacity select, flush, fill count and watermark flags
`timescale 1ns/1ps
module bfw_byte_fifo #(
  parameter int DEPTH = 512,
  parameter int ADDR_WIDTH = 9
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [7:0] regAddr,
  input wire logic useAddr,
  input wire logic [7:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regReadData,
  output logic [7:0] addrPointer,
  output logic nearFullFlag,
  output logic nearEmptyFlag,
  output logic irq
);

  //------------------------------------------------------------
  // declarations
  //------------------------------------------------------------
  logic capacitySelect;
  logic thresholdMsb;
  logic [7:0] thresholdLevel;
  logic [9:0] fillCount;
  logic [ADDR_WIDTH-1:0] writePtr;
  logic [ADDR_WIDTH-1:0] readPtr;
  logic [1:0] irqEnable;
  logic nearFullPrev;
  logic nearEmptyPrev;

  logic [7:0] accessAddr;
  logic anyAccess;
  logic hitControl;
  logic hitThreshold;
  logic hitFillCount;
  logic hitDataPort;
  logic hitIrqStatus;
  logic hitIrqClear;
  logic hitIrqEnable;

  logic [9:0] capacity;
  logic [9:0] threshold;
  logic [9:0] freeSpace;
  logic overCapacity;
  logic nearFull;
  logic nearEmpty;
  logic bufferFull;
  logic bufferEmpty;
  logic pushByte;
  logic popByte;
  logic clearBuffer;
  logic [ADDR_WIDTH-1:0] next_writePtr;
  logic [ADDR_WIDTH-1:0] next_readPtr;
  logic [9:0] next_fillCount;
  logic [7:0] next_addrPointer;

  logic nearFullRise;
  logic nearEmptyRise;
  logic nearFullEvent;
  logic nearEmptyEvent;
  logic [1:0] irqStatus;
  logic [1:0] countUpper;
  logic [7:0] controlRead;
  logic [7:0] next_readData;

  bfw_mem_if #(.ADDR_WIDTH(ADDR_WIDTH), .DATA_WIDTH(8)) memPort ();

  //------------------------------------------------------------
  // address decode
  //------------------------------------------------------------
  // a burst continues from the internal pointer when useAddr is low
  assign accessAddr = useAddr ? regAddr : addrPointer;
  assign anyAccess = regWrite | regRead;
  assign hitControl = accessAddr == bfw_pkg::OFS_CONTROL;
  assign hitThreshold = accessAddr == bfw_pkg::OFS_THRESHOLD;
  assign hitFillCount = accessAddr == bfw_pkg::OFS_FILL_COUNT;
  assign hitDataPort = accessAddr == bfw_pkg::OFS_DATA_PORT;
  assign hitIrqStatus = accessAddr == bfw_pkg::OFS_IRQ_STATUS;
  assign hitIrqClear = accessAddr == bfw_pkg::OFS_IRQ_CLEAR;
  assign hitIrqEnable = accessAddr == bfw_pkg::OFS_IRQ_ENABLE;
  // unmapped addresses hit nothing: writes vanish and reads give zero

  // the pointer stays on the data port so a burst keeps hitting it
  assign next_addrPointer = hitDataPort ? accessAddr :
    accessAddr + 8'h01;

  //------------------------------------------------------------
  // capacity and watermark
  //------------------------------------------------------------
  assign capacity = capacitySelect ? bfw_pkg::CAPACITY_SMALL :
    bfw_pkg::CAPACITY_LARGE;
  // threshold msb ignored in the 255-byte mode
  assign threshold = {1'b0, thresholdMsb & ~capacitySelect,
    thresholdLevel};
  assign overCapacity = fillCount > capacity;
  // a capacity shrink with data inside must not wrap the free space
  assign freeSpace = overCapacity ? 10'h000 : capacity - fillCount;
  assign nearFull = freeSpace <= threshold;
  assign nearEmpty = fillCount <= threshold;
  assign bufferFull = fillCount >= capacity;
  assign bufferEmpty = fillCount == 10'h000;

  //------------------------------------------------------------
  // push, pop and flush
  //------------------------------------------------------------
  assign clearBuffer = regWrite & hitControl &
    regWriteData[bfw_pkg::CTL_BUFFER_CLEAR];
  // overflowing bytes are dropped, not wrapped over unread data
  assign pushByte = regWrite & hitDataPort & ~bufferFull;
  assign popByte = regRead & hitDataPort & ~bufferEmpty;

  always_comb begin
    next_writePtr = writePtr;
    next_readPtr = readPtr;
    next_fillCount = fillCount;
    if (clearBuffer) begin
      next_writePtr = '0;
      next_readPtr = '0;
      next_fillCount = bfw_pkg::RST_FILL_COUNT;
    end else if (pushByte) begin
      next_writePtr = writePtr + 1'b1;
      next_fillCount = fillCount + 10'h001;
    end else if (popByte) begin
      next_readPtr = readPtr + 1'b1;
      next_fillCount = fillCount - 10'h001;
    end
  end

  assign memPort.writeEnable = pushByte;
  assign memPort.writeAddr = writePtr;
  assign memPort.writeData = regWriteData;
  // storage always presents the byte at the next head
  assign memPort.readAddr = next_readPtr;

  bfw_mem #(
    .DEPTH(DEPTH),
    .ADDR_WIDTH(ADDR_WIDTH),
    .DATA_WIDTH(8)
  ) u_mem (
    .clk(clk),
    .ce(ce),
    .port(memPort.store)
  );

  //------------------------------------------------------------
  // watermark events and interrupt
  //------------------------------------------------------------
  // a clear meeting a new rise loses, so no event is ever missed
  assign nearFullRise = nearFull & ~nearFullPrev;
  assign nearEmptyRise = nearEmpty & ~nearEmptyPrev;

  bfw_sticky_flag u_nearFullEvent (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .set(nearFullRise),
    .clear(regWrite & hitIrqClear &
      regWriteData[bfw_pkg::IRQ_NEAR_FULL_EVENT]),
    .flag(nearFullEvent)
  );

  bfw_sticky_flag u_nearEmptyEvent (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .set(nearEmptyRise),
    .clear(regWrite & hitIrqClear &
      regWriteData[bfw_pkg::IRQ_NEAR_EMPTY_EVENT]),
    .flag(nearEmptyEvent)
  );

  assign irqStatus = {nearFullEvent, nearEmptyEvent};

  //------------------------------------------------------------
  // read data selection
  //------------------------------------------------------------
  // upper count bits only meaningful in 512-byte mode
  assign countUpper = capacitySelect ? 2'h0 : fillCount[9:8];
  assign controlRead = {capacitySelect, nearFull, nearEmpty,
    1'b0, 1'b0, thresholdMsb, countUpper};

  // an empty pop gives zero, never a stale byte of the array
  always_comb begin
    next_readData = 8'h00;
    if (hitControl) begin
      next_readData = controlRead;
    end else if (hitThreshold) begin
      next_readData = thresholdLevel;
    end else if (hitFillCount) begin
      next_readData = fillCount[7:0];
    end else if (hitDataPort) begin
      next_readData = bufferEmpty ? 8'h00 : memPort.readData;
    end else if (hitIrqStatus) begin
      next_readData = {6'h00, irqStatus};
    end else if (hitIrqEnable) begin
      next_readData = {6'h00, irqEnable};
    end
  end

  //------------------------------------------------------------
  // control registers
  //------------------------------------------------------------
  // a capacity change with data inside is not blocked; software clears
  // first, otherwise the count may sit above the new capacity
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      capacitySelect <= bfw_pkg::RST_CAPACITY_SELECT;
      thresholdMsb <= bfw_pkg::RST_THRESHOLD_MSB;
    end else if (ce && regWrite && hitControl) begin
      capacitySelect <= regWriteData[bfw_pkg::CTL_CAPACITY_SELECT];
      thresholdMsb <= regWriteData[bfw_pkg::CTL_THRESHOLD_MSB];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      thresholdLevel <= bfw_pkg::RST_THRESHOLD;
    end else if (ce && regWrite && hitThreshold) begin
      thresholdLevel <= regWriteData;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irqEnable <= bfw_pkg::RST_IRQ_ENABLE;
    end else if (ce && regWrite && hitIrqEnable) begin
      irqEnable <= regWriteData[1:0];
    end
  end

  //------------------------------------------------------------
  // buffer state
  //------------------------------------------------------------
  // pointers wrap at the array depth; 255-byte mode only stops earlier
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      writePtr <= '0;
      readPtr <= '0;
      fillCount <= bfw_pkg::RST_FILL_COUNT;
    end else if (ce) begin
      writePtr <= next_writePtr;
      readPtr <= next_readPtr;
      fillCount <= next_fillCount;
    end
  end

  // previous status starts high so reset itself raises no event
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      nearFullPrev <= 1'b1;
      nearEmptyPrev <= 1'b1;
    end else if (ce) begin
      nearFullPrev <= nearFull;
      nearEmptyPrev <= nearEmpty;
    end
  end

  //------------------------------------------------------------
  // outputs
  //------------------------------------------------------------
  // read data stands for one enabled cycle and is zero otherwise; it holds while ce is low
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      regReadData <= bfw_pkg::RST_READ_DATA;
    end else if (ce) begin
      regReadData <= regRead ? next_readData : 8'h00;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      addrPointer <= bfw_pkg::RST_ADDR_POINTER;
    end else if (ce && anyAccess) begin
      addrPointer <= next_addrPointer;
    end
  end

  // flags are registered copies, one cycle behind the count
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      nearFullFlag <= 1'b0;
      nearEmptyFlag <= 1'b0;
    end else if (ce) begin
      nearFullFlag <= nearFull;
      nearEmptyFlag <= nearEmpty;
    end
  end

  // level output: high until the event is cleared or disabled
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(irqStatus & irqEnable);
    end
  end

endmodule

// *** bfw_byte_fifo_props.sv ***
// checker on the ports of the byte fifo
`timescale 1ns/1ps
module bfw_byte_fifo_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [7:0] regAddr,
  input wire logic useAddr,
  input wire logic [7:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regReadData,
  input wire logic [7:0] addrPointer,
  input wire logic nearFullFlag,
  input wire logic nearEmptyFlag,
  input wire logic irq
);
  // ----
  // assertions
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire acc = ce && (regWrite || regRead) && useAddr;
  wire rdA = ce && regRead && useAddr;
  wire hole = regAddr > 8'h08 || regAddr < 8'h02;
  a_ptr_data_hold: assert property (
    acc && regAddr == 8'h05 |=> addrPointer == 8'h05)
    else $error("pointer moved on data port");
  a_ptr_advance: assert property (
    acc && regAddr != 8'h05 |=> addrPointer == $past(regAddr) + 8'h01)
    else $error("pointer did not advance");
  a_ptr_idle_hold: assert property (
    ce && !regWrite && !regRead |=> $stable(addrPointer))
    else $error("pointer moved while idle");
  a_freeze_hold: assert property (
    !ce |=> $stable(addrPointer) && $stable(regReadData))
    else $error("state moved with clock enable low");
  a_read_idle_zero: assert property (
    ce && !regRead |=> regReadData == 8'h00)
    else $error("read data outside its cycle");
  a_clear_reads_zero: assert property (
    rdA && regAddr == 8'h02 |=> regReadData[4:3] == 2'b00)
    else $error("clear bit read back");
  a_flags_match: assert property (
    rdA && regAddr == 8'h02 |=>
    regReadData[6:5] == {nearFullFlag, nearEmptyFlag})
    else $error("status bits disagree with flags");
  a_unmapped_zero: assert property (
    rdA && hole |=> regReadData == 8'h00)
    else $error("unmapped read not zero");
  c_push: cover property (acc && regWrite && regAddr == 8'h05);
  c_ctl_read: cover property (rdA && regAddr == 8'h02);
  c_irq: cover property ($rose(irq));
  c_b2b: cover property ((ce && regWrite) ##1 (ce && regRead));
endmodule
bind bfw_byte_fifo bfw_byte_fifo_props bfw_byte_fifo_props_i (
  .clk(clk), .reset(reset), .ce(ce), .regAddr(regAddr),
  .useAddr(useAddr), .regWriteData(regWriteData), .regWrite(regWrite),
  .regRead(regRead), .regReadData(regReadData),
  .addrPointer(addrPointer), .nearFullFlag(nearFullFlag),
  .nearEmptyFlag(nearEmptyFlag), .irq(irq));

// *** bfw_host_model.sv ***
// host side model driving the register port
`timescale 1ns/1ps
module bfw_host_model (
  input wire logic clk,
  input wire logic [7:0] regReadData,
  output logic ce,
  output logic [7:0] regAddr,
  output logic useAddr,
  output logic [7:0] regWriteData,
  output logic regWrite,
  output logic regRead
);
  logic u = 1'b1;
  logic en = 1'b1;
  initial begin
    ce = 1'b1;
    useAddr = 1'b1;
    regAddr = 8'h00;
    regWriteData = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
  end
  // released lines show the inverse, never the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    ce <= en;
    useAddr <= u;
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    ce <= 1'b1;
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWriteData <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    useAddr <= u;
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    regAddr <= ~a;
    @(negedge clk);
    d = regReadData;
  endtask
  // write then read with no idle cycle between the strobes
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] dw,
    output logic [7:0] d);
    @(posedge clk);
    useAddr <= u;
    regAddr <= a;
    regWriteData <= dw;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    regWriteData <= ~dw;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    regAddr <= ~a;
    @(negedge clk);
    d = regReadData;
  endtask
endmodule

// *** bfw_byte_fifo_tb_top.sv ***
// testbench for the byte fifo with watermark flags
`timescale 1ns/1ps
module bfw_byte_fifo_tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ce, useAddr, regWrite, regRead;
  logic [7:0] regAddr, regWriteData, regReadData, addrPointer, r;
  logic nearFullFlag, nearEmptyFlag, irq;
  int failures = 0;
  int n_checks = 0;
  logic [7:0] q[$];
  logic [9:0] cap = 10'h200;
  logic [9:0] thr = 10'h000;
  always #25 clk = ~clk;
  bfw_host_model bfw_host_model_i (.clk(clk), .regReadData(regReadData),
    .ce(ce), .regAddr(regAddr), .useAddr(useAddr),
    .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead));
  bfw_byte_fifo bfw_byte_fifo_i (.clk(clk), .reset(reset), .ce(ce),
    .regAddr(regAddr), .useAddr(useAddr), .regWriteData(regWriteData),
    .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
    .addrPointer(addrPointer), .nearFullFlag(nearFullFlag),
    .nearEmptyFlag(nearEmptyFlag), .irq(irq));
  // ----
  // helpers
  // ----
  task automatic chk(input logic [9:0] s, input logic [9:0] e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic tally_and_finish;
    if (failures == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    bfw_host_model_i.wr(a, d);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    bfw_host_model_i.rd(a, d);
  endtask
  // flags lag the count by one cycle
  task automatic flags;
    @(negedge clk);
    @(negedge clk);
    chk(nearFullFlag, cap - 10'(q.size()) <= thr);
    chk(nearEmptyFlag, 10'(q.size()) <= thr);
  endtask
  task automatic push(input logic [7:0] d);
    w(8'h05, d);
    if (q.size() < cap) q.push_back(d);
    flags;
  endtask
  task automatic pop;
    logic [7:0] e;
    e = q.size() ? q.pop_front() : 8'h00;
    rd(8'h05, r);
    chk(r, e);
    flags;
  endtask
  task automatic cnt;
    logic [9:0] n;
    n = 10'(q.size());
    rd(8'h04, r);
    chk(r, n[7:0]);
    rd(8'h02, r);
    chk(r[1:0], cap[9] ? n[9:8] : 2'b00);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_reset;
    chk(addrPointer, 8'h00);
    rd(8'h02, r);
    chk(r, 8'h20);
    rd(8'h04, r);
    chk(r, 8'h00);
    rd(8'h06, r);
    chk(r, 8'h00);
    rd(8'h10, r);
    chk(r, 8'h00);
    w(8'h03, 8'ha5);
    rd(8'h03, r);
    chk(r, 8'ha5);
  endtask
  task automatic t_fill512;
    thr = 10'h105;
    w(8'h03, 8'h05);
    w(8'h02, 8'h04);
    for (int i = 0; i < 513; i++) push(8'(i) ^ 8'h5a);
    cnt;
    pop;
    bfw_host_model_i.u = 1'b0;
    for (int i = 0; i < 512; i++) pop;
    chk(addrPointer, 8'h05);
    bfw_host_model_i.u = 1'b1;
    cnt;
  endtask
  task automatic t_irq;
    rd(8'h06, r);
    chk(r, 8'h03);
    chk(irq, 1'b0);
    w(8'h08, 8'h02);
    flags;
    chk(irq, 1'b1);
    w(8'h06, 8'h00);
    w(8'h07, 8'h02);
    flags;
    chk(irq, 1'b0);
    rd(8'h06, r);
    chk(r, 8'h01);
    w(8'h07, 8'h01);
    rd(8'h06, r);
    chk(r, 8'h00);
    rd(8'h08, r);
    chk(r, 8'h02);
  endtask
  task automatic t_small;
    w(8'h02, 8'h10);
    cap = 10'h0ff;
    thr = 10'h003;
    w(8'h02, 8'h84);
    w(8'h03, 8'h03);
    bfw_host_model_i.en = 1'b0;
    w(8'h05, 8'h77);
    bfw_host_model_i.en = 1'b1;
    cnt;
    for (int i = 0; i < 256; i++) push(8'(i));
    cnt;
    rd(8'h02, r);
    chk(r, 8'hc4);
    w(8'h02, 8'h90);
    q.delete();
    flags;
    rd(8'h02, r);
    chk(r, 8'ha0);
    cnt;
  endtask
  task automatic t_again;
    bfw_host_model_i.wr_rd(8'h05, 8'h3c, r);
    chk(r, 8'h3c);
    cnt;
    w(8'h05, 8'h11);
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    cap = bfw_pkg::CAPACITY_LARGE;
    thr = 10'h000;
    chk(addrPointer, bfw_pkg::RST_ADDR_POINTER);
    flags;
    rd(8'h02, r);
    chk(r, 8'h20);
    rd(8'h06, r);
    chk(r, 8'h00);
    cnt;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_reset;
    t_fill512;
    t_irq;
    t_small;
    t_again;
    tally_and_finish;
  end
  initial begin
    #1000000;
    failures++;
    tally_and_finish;
  end
endmodule
